// ===== arc_pkg.sv
// Constants and types for the acquisition run control block
package arc_pkg;

  // ****************************************
  // APB map
  // ****************************************
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_AVERAGING = 8'h04;
  localparam logic [7:0] ADDR_ENVELOPE  = 8'h08;
  localparam logic [7:0] ADDR_RUNSTATE  = 8'h0C;
  localparam logic [7:0] ADDR_TALLY     = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;

  // Control register fields
  localparam int CTL_MODE_LSB  = 0;
  localparam int CTL_SEQ_BIT   = 2;

  // Status register fields
  localparam int STS_REJ_BIT   = 0;
  localparam int STS_SEQ_BIT   = 1;
  localparam int STS_BUSY_BIT  = 2;

  // ****************************************
  // Counts
  // ****************************************
  localparam int          TALLY_W       = 30;
  localparam int          SEQ_W         = 10;
  localparam logic [31:0] COUNT_MIN     = 32'h0000_0002;
  localparam logic [31:0] COUNT_MAX     = 32'h0000_0200;
  localparam logic [31:0] ENV_INFINITE  = 32'h3B9A_C9FF;
  localparam logic [31:0] ENV_ZERO      = 32'h0000_0000;
  localparam logic [9:0]  ENV_SEQ_LIMIT = 10'h201;
  localparam logic [9:0]  AVG_RESET     = 10'h010;
  localparam logic [9:0]  ENV_RESET     = 10'h008;

  typedef enum logic [1:0] {
    ARC_SAMPLE,
    ARC_PEAK,
    ARC_AVERAGE,
    ARC_ENVELOPE
  } arc_mode_t;

  typedef enum logic {
    ARC_STOPPED,
    ARC_RUNNING
  } arc_run_t;

endpackage

// ===== arc_pow2_check.sv
// Checks a written count against the allowed power-of-two range
`timescale 1ns/10ps
module arc_pow2_check (
  input  wire logic [31:0] value,
  output logic             legal
);
  import arc_pkg::*;

  always_comb begin
    legal = (value >= COUNT_MIN) && (value <= COUNT_MAX) && ((value & (value - 32'h1)) == 32'h0);
  end
endmodule

// ===== arc_run_control.sv
// Acquisition run control with APB register access
`timescale 1ns/10ps
module arc_run_control (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                clkEn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                acqDone,
  input  wire logic                settingChanged,
  input  wire logic                signalStop,
  output logic                     running,
  output logic                     sequenceRestart,
  output logic      [9:0]          activeCount
);
  import arc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    arc_run_t          runState;
    arc_mode_t         mode;
    logic              singleSeq;
    logic [9:0]        avgCount;
    logic [9:0]        envCount;
    logic              envInfinite;
    logic [TALLY_W-1:0] tally;
    logic [SEQ_W-1:0]  seqCount;
    logic              rejected;
    logic              seqDone;
    logic [31:0]       rdata;
    logic              ready;
    logic              slvErr;
    logic              restart;
    logic [9:0]        target;
  } arc_state_t;

  arc_state_t state;
  arc_state_t next_state;
  logic       countLegal;
  logic       access;
  logic       wrAccess;
  logic       runCmd;
  logic       stopCmd;
  logic [9:0] seqGoal;
  logic       seqInfinite;

  arc_pow2_check u_check (
    .value (pwdata),
    .legal (countLegal)
  );

  // Access phase taken in one cycle; pready rises with the registered answer
  assign access   = psel && penable && !state.ready;
  assign wrAccess = access && pwrite;
  assign runCmd   = wrAccess && (paddr == ADDR_RUNSTATE) && (pwdata != 32'h0);
  assign stopCmd  = wrAccess && (paddr == ADDR_RUNSTATE) && (pwdata == 32'h0);

  // Sequence length in the current mode; one for sample and peak modes
  always_comb begin
    seqGoal     = 10'h001;
    seqInfinite = 1'b0;
    unique case (state.mode)
      ARC_AVERAGE: seqGoal = state.avgCount;
      ARC_ENVELOPE: begin
        if (state.envInfinite) begin
          seqGoal     = ENV_SEQ_LIMIT;
          seqInfinite = 1'b1;
        end else begin
          seqGoal = state.envCount;
        end
      end
      ARC_SAMPLE, ARC_PEAK: seqGoal = 10'h001;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_state         = state;
    next_state.ready   = 1'b0;
    next_state.slvErr  = 1'b0;
    next_state.restart = 1'b0;
    next_state.target  = seqGoal;

    // Acquisitions completing while running
    if (acqDone && state.runState == ARC_RUNNING) begin
      if (state.tally != {TALLY_W{1'b1}}) begin
        next_state.tally = state.tally + {{(TALLY_W-1){1'b0}}, 1'b1};
      end
      if (state.singleSeq && (state.seqCount + 10'h001 >= seqGoal)) begin
        next_state.runState = ARC_STOPPED;
        next_state.seqDone  = 1'b1;
        next_state.seqCount = '0;
      end else if (state.mode == ARC_ENVELOPE && !seqInfinite
                   && (state.seqCount + 10'h001 >= seqGoal)) begin
        next_state.seqCount = '0;
        next_state.restart  = 1'b1;
      end else if (!(state.mode == ARC_ENVELOPE && seqInfinite && !state.singleSeq)) begin
        next_state.seqCount = state.seqCount + 10'h001;
      end
    end

    // Other signal events end a single sequence
    if (signalStop && state.singleSeq && state.runState == ARC_RUNNING) begin
      next_state.runState = ARC_STOPPED;
    end

    if (settingChanged) begin
      next_state.tally = '0;
    end

    // Register accesses
    if (access) begin
      next_state.ready = 1'b1;
      next_state.rdata = 32'h0;
      if (pwrite) begin
        unique case (paddr)
          ADDR_CONTROL: begin
            next_state.mode      = arc_mode_t'(pwdata[CTL_MODE_LSB +: 2]);
            next_state.singleSeq = pwdata[CTL_SEQ_BIT];
            next_state.tally     = '0;
            next_state.seqCount  = '0;
          end
          ADDR_AVERAGING: begin
            if (countLegal) begin
              next_state.avgCount = pwdata[9:0];
              next_state.tally    = '0;
            end else begin
              next_state.rejected = 1'b1;
              next_state.slvErr   = 1'b1;
            end
          end
          ADDR_ENVELOPE: begin
            if (pwdata == ENV_INFINITE || pwdata == ENV_ZERO) begin
              next_state.envInfinite = 1'b1;
              next_state.tally       = '0;
            end else if (countLegal) begin
              next_state.envInfinite = 1'b0;
              next_state.envCount    = pwdata[9:0];
              next_state.tally       = '0;
            end else begin
              next_state.rejected = 1'b1;
              next_state.slvErr   = 1'b1;
            end
          end
          ADDR_RUNSTATE: begin
            if (runCmd) begin
              next_state.runState = ARC_RUNNING;
              next_state.tally    = '0;
              next_state.seqCount = '0;
              next_state.seqDone  = 1'b0;
              next_state.restart  = 1'b1;
            end else if (stopCmd) begin
              next_state.runState = ARC_STOPPED;
            end
          end
          ADDR_STATUS: begin
            // Write one to clear the rejected flag
            if (pwdata[STS_REJ_BIT]) begin
              next_state.rejected = 1'b0;
            end
          end
          default: next_state.slvErr = (paddr != ADDR_TALLY);
        endcase
      end else begin
        unique case (paddr)
          ADDR_CONTROL: begin
            next_state.rdata[CTL_MODE_LSB +: 2] = state.mode;
            next_state.rdata[CTL_SEQ_BIT]       = state.singleSeq;
          end
          ADDR_AVERAGING: next_state.rdata = {22'h0, state.avgCount};
          ADDR_ENVELOPE: begin
            next_state.rdata = state.envInfinite ? ENV_INFINITE
                                                 : {22'h0, state.envCount};
          end
          ADDR_RUNSTATE: next_state.rdata = {31'h0, state.runState == ARC_RUNNING};
          ADDR_TALLY: next_state.rdata = {2'h0, state.tally};
          ADDR_STATUS: begin
            next_state.rdata[STS_REJ_BIT]  = state.rejected;
            next_state.rdata[STS_SEQ_BIT]  = state.seqDone;
            next_state.rdata[STS_BUSY_BIT] = state.runState == ARC_RUNNING;
          end
          default: next_state.slvErr = 1'b1;
        endcase
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Synchronous reset; clkEn low freezes everything including the bus answer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state             <= '0;
      state.runState    <= ARC_STOPPED;
      state.mode        <= ARC_SAMPLE;
      state.avgCount    <= AVG_RESET;
      state.envCount    <= ENV_RESET;
      state.target      <= 10'h001;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  assign prdata          = state.rdata;
  assign pready          = state.ready;
  assign pslverr         = state.slvErr;
  assign running         = state.runState;
  assign sequenceRestart = state.restart;
  assign activeCount     = state.target;
endmodule

// ===== arc_run_control_asserts.sv
// Port assertions for the run control block
`timescale 1ns/10ps
module arc_run_control_chk
  import arc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        clkEn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        running,
  input wire logic        sequenceRestart
);
  logic acc;
  logic runWr;
  logic badAvg;
  assign acc = psel && penable && !pready && clkEn;
  assign runWr = acc && pwrite && paddr == ADDR_RUNSTATE && pwdata != 32'h0;
  assign badAvg = $countones(pwdata) != 1 || pwdata < COUNT_MIN || pwdata > COUNT_MAX;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  answer_next_a: assert property (acc |=> pready)
    else $error("no answer after access");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without answer");
  run_start_a: assert property (runWr |=> running && sequenceRestart)
    else $error("run write did not start");
  run_stop_a: assert property (acc && pwrite && paddr == ADDR_RUNSTATE && pwdata == 32'h0 |=> !running)
    else $error("stop write did not stop");
  start_cause_a: assert property ($rose(running) |-> $past(runWr))
    else $error("started without run write");
  bad_avg_a: assert property (acc && pwrite && paddr == ADDR_AVERAGING && badAvg |=> pslverr)
    else $error("illegal average count taken");
  good_avg_a: assert property (acc && pwrite && paddr == ADDR_AVERAGING && !badAvg |=> !pslverr)
    else $error("legal average count refused");
  env_inf_a: assert property (acc && pwrite && paddr == ADDR_ENVELOPE
    && (pwdata == ENV_ZERO || pwdata == ENV_INFINITE) |=> !pslverr)
    else $error("infinite envelope refused");
  cover property (runWr);
  cover property (sequenceRestart);
  cover property (pslverr);
endmodule
bind arc_run_control arc_run_control_chk chk (.ref_clk, .rst_n, .clkEn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .running, .sequenceRestart);

// ===== arc_host_model.sv
// Remote host controller model issuing register commands over APB
`timescale 1ns/10ps
module arc_host_model (
  input  wire logic        ref_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Called just after an edge; spare edge at the end avoids re-driving in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge ref_clk);
  endtask
endmodule

// ===== acquisition_run_control_test.sv
// Self-checking bench for the acquisition run control block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module acquisition_run_control_test;
  import arc_pkg::*;
  logic ref_clk, rst_n, clkEn, psel, penable, pwrite, pready, pslverr, e;
  logic acqDone, settingChanged, signalStop, running, sequenceRestart;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [9:0] activeCount;
  int n_errors, tests_run, cyc, nRestart;
  arc_run_control dut (.ref_clk, .rst_n, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .acqDone, .settingChanged, .signalStop, .running,
    .sequenceRestart, .activeCount);
  arc_host_model host (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task acq(input int n);
    repeat (n) begin
      acqDone <= 1'b1;
      @(posedge ref_clk);
      acqDone <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bound on the whole run, well above the expected length
  always @(posedge ref_clk) begin
    cyc++;
    if (sequenceRestart === 1'b1) nRestart++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    {rst_n, acqDone, settingChanged, signalStop} = 4'h0;
    clkEn = 1'b1;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(ADDR_AVERAGING); `CHK("avg", 32'h10, q)
    rd(ADDR_RUNSTATE); `CHK("state", 32'h0, q)
    for (int i = 1; i < 10; i++) begin
      wr(ADDR_AVERAGING, 32'h1 << i);
      rd(ADDR_AVERAGING); `CHK("avg", 32'h1 << i, q)
      wr(ADDR_ENVELOPE, 32'h1 << i);
      rd(ADDR_ENVELOPE); `CHK("env", 32'h1 << i, q)
    end
    wr(ADDR_AVERAGING, 32'h3); `CHK("avg err", 1'b1, e)
    wr(ADDR_ENVELOPE, 32'h400); `CHK("env err", 1'b1, e)
    rd(ADDR_AVERAGING); `CHK("avg kept", 32'h200, q)
    rd(ADDR_STATUS); `CHK("rejected", 32'h1, q)
    wr(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS); `CHK("rej clear", 32'h0, q)
    rd(8'h20); `CHK("unmapped", 1'b1, e)
    wr(ADDR_ENVELOPE, ENV_ZERO);
    rd(ADDR_ENVELOPE); `CHK("env inf", ENV_INFINITE, q)
    $display("test counts done");
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_RUNSTATE, 32'h5);
    rd(ADDR_RUNSTATE); `CHK("state", 32'h1, q)
    acq(3);
    rd(ADDR_TALLY); `CHK("tally", 32'h3, q)
    wr(ADDR_RUNSTATE, 32'h1);
    rd(ADDR_TALLY); `CHK("tally run", 32'h0, q)
    acq(2);
    settingChanged <= 1'b1;
    @(posedge ref_clk);
    settingChanged <= 1'b0;
    rd(ADDR_TALLY); `CHK("tally chg", 32'h0, q)
    wr(ADDR_RUNSTATE, 32'h0); `CHK("running", 1'b0, running)
    $display("test tally done");
    wr(ADDR_ENVELOPE, 32'h2);
    wr(ADDR_CONTROL, 32'h3);
    wr(ADDR_RUNSTATE, 32'h1); `CHK("length", 10'h2, activeCount)
    nRestart = 0;
    acq(4);
    @(posedge ref_clk);
    `CHK("restarts", 2, nRestart)
    wr(ADDR_ENVELOPE, ENV_ZERO);
    wr(ADDR_CONTROL, 32'h7);
    wr(ADDR_RUNSTATE, 32'h1); `CHK("length inf", ENV_SEQ_LIMIT, activeCount)
    wr(ADDR_AVERAGING, 32'h4);
    wr(ADDR_CONTROL, 32'h6);
    wr(ADDR_RUNSTATE, 32'h1);
    acq(3); `CHK("run avg", 1'b1, running)
    acq(1); `CHK("stop avg", 1'b0, running)
    rd(ADDR_STATUS); `CHK("seq done", 32'h2, q)
    wr(ADDR_CONTROL, 32'h4);
    wr(ADDR_RUNSTATE, 32'h1);
    signalStop <= 1'b1;
    @(posedge ref_clk);
    signalStop <= 1'b0;
    @(posedge ref_clk);
    `CHK("event stop", 1'b0, running)
    $display("test sequences done");
    final_report();
  end
endmodule
